// ### rtl/clb_pkg.sv
// constants for the can loopback transmit and receive path
package clb_pkg;
    localparam int CLB_ID_W = 11;
    localparam int CLB_NBUF = 2;
    localparam int CLB_NFILT = 3;
    localparam int CLB_NBYTE = 8;

    // register map, byte addresses on the 8-bit register port
    localparam logic [7:0] CLB_ADDR_MODE = 8'h00;
    localparam logic [7:0] CLB_ADDR_IE = 8'h01;
    localparam logic [7:0] CLB_ADDR_IF = 8'h02;
    localparam logic [7:0] CLB_ADDR_BT0 = 8'h03;
    localparam logic [7:0] CLB_ADDR_BT2 = 8'h05;
    localparam logic [7:0] CLB_ADDR_FILT0 = 8'h08;
    localparam logic [7:0] CLB_ADDR_MASK0 = 8'h10;
    localparam logic [2:0] CLB_TXBUF_PAGE = 3'h1;
    localparam logic [2:0] CLB_RXBUF_PAGE = 3'h2;
    localparam logic [3:0] CLB_BUF_CTRL = 4'h0;
    localparam logic [3:0] CLB_BUF_IDHI = 4'h1;
    localparam logic [3:0] CLB_BUF_IDLO = 4'h2;
    localparam logic [3:0] CLB_BUF_LEN = 4'h3;
    localparam logic [3:0] CLB_BUF_DATA0 = 4'h4;
    localparam logic [3:0] CLB_BUF_DATA7 = 4'hb;

    // field positions
    localparam int CLB_MODE_LSB = 5;
    localparam int CLB_TX_REQ_BIT = 3;
    localparam int CLB_RX0_FULL_BIT = 0;
    localparam int CLB_RX1_FULL_BIT = 1;
    localparam int CLB_TX0_DONE_BIT = 2;
    localparam int CLB_TX1_DONE_BIT = 3;

    // operating modes in the three top bits of the mode register
    localparam logic [2:0] CLB_MODE_NORMAL = 3'h0;
    localparam logic [2:0] CLB_MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] CLB_MODE_CONFIG = 3'h4;

    localparam logic [7:0] CLB_MODE_RESET = 8'h80;
    localparam logic [7:0] CLB_IE_RESET = 8'h00;
    localparam logic [7:0] CLB_IF_RESET = 8'h00;

    typedef enum logic [0:0] {CLB_IDLE, CLB_SEND} clb_state_e;
endpackage

// ### rtl/clb_accept_filter.sv
// acceptance filter: compares a frame identifier against masked filters
`timescale 1ns/1ns
`default_nettype none
module clb_accept_filter
    import clb_pkg::*;
#(
    parameter int ID_W = CLB_ID_W,
    parameter int NFILT = CLB_NFILT
) (
    input wire logic [ID_W-1:0] frame_id,
    input wire logic [NFILT-1:0][ID_W-1:0] filt,
    input wire logic [1:0][ID_W-1:0] mask,
    output logic hit_rx0,
    output logic hit_rx1
);
    logic [NFILT-1:0] match;

    // filters 0 and 1 use mask 0 (buffer 0), the rest use mask 1 (buffer 1)
    genvar gi;
    generate
        for (gi = 0; gi < NFILT; gi++) begin : g_filt
            localparam int MSEL = (gi < 2) ? 0 : 1;
            assign match[gi] = ((frame_id ^ filt[gi]) & mask[MSEL]) == '0;
        end
    endgenerate

    assign hit_rx0 = match[0] | match[1];
    assign hit_rx1 = |match[NFILT-1:2];
endmodule
`default_nettype wire

// ### rtl/clb_core.sv
// can controller loopback path: registers, transmit buffers, receive buffers
// What this block does
// - loopback needs no bit timing setup
// - enable value 0x01 routes only rx0 full
// - receive buffer accepts only when flag clear
// - loopback frame filtered, stored in matching buffer
// - looped frame readable from receive buffer registers
// - clearing rx0 flag frees buffer, drops interrupt
// - two selectable transmit buffers, length up to 8
// - top three mode bits select operating mode
// - enables route flags; host writes flags freely
`timescale 1ns/1ns
`default_nettype none
module clb_core
    import clb_pkg::*;
#(
    parameter int ID_W = CLB_ID_W
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq_n
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ie;
        logic [7:0] iflag;
        logic [2:0][7:0] bt;
        logic [CLB_NFILT-1:0][ID_W-1:0] filt;
        logic [1:0][ID_W-1:0] mask;
        logic [CLB_NBUF-1:0] tx_req;
        logic [CLB_NBUF-1:0][ID_W-1:0] txid;
        logic [CLB_NBUF-1:0][3:0] txlen;
        logic [CLB_NBUF-1:0][CLB_NBYTE-1:0][7:0] txdat;
        logic [CLB_NBUF-1:0][ID_W-1:0] rxid;
        logic [CLB_NBUF-1:0][3:0] rxlen;
        logic [CLB_NBUF-1:0][CLB_NBYTE-1:0][7:0] rxdat;
        clb_state_e st;
        logic sel;
        logic [7:0] rdata;
    } clb_regs_s;

    clb_regs_s r_reg;
    clb_regs_s r_next;
    logic hit_rx0;
    logic hit_rx1;
    logic [2:0] mode;
    logic cfg_mode;
    logic tx_page;
    logic rx_page;
    logic [3:0] fld;
    logic bufn;
    logic [2:0] didx;

    assign mode = r_reg.mode[7:CLB_MODE_LSB];
    assign cfg_mode = (mode == CLB_MODE_CONFIG);
    assign tx_page = reg_addr[7:5] == CLB_TXBUF_PAGE;
    assign rx_page = reg_addr[7:5] == CLB_RXBUF_PAGE;
    assign fld = reg_addr[3:0];
    assign bufn = reg_addr[4];
    assign didx = 3'(fld - CLB_BUF_DATA0);

    clb_accept_filter #(
        .ID_W(ID_W),
        .NFILT(CLB_NFILT)
    ) u_filter (
        .frame_id(r_reg.txid[r_reg.sel]),
        .filt(r_reg.filt),
        .mask(r_reg.mask),
        .hit_rx0(hit_rx0),
        .hit_rx1(hit_rx1)
    );

    always_comb begin
        logic [7:0] rd_val;
        logic [3:0] fidx;
        logic ctrl_wr_sel;
        rd_val = 8'h00;
        fidx = 4'(reg_addr - CLB_ADDR_FILT0);
        ctrl_wr_sel = 1'b0;
        r_next = r_reg;

        // read mux; unmapped addresses read as zero
        if (reg_addr == CLB_ADDR_MODE) begin
            rd_val = r_reg.mode;
        end else if (reg_addr == CLB_ADDR_IE) begin
            rd_val = r_reg.ie;
        end else if (reg_addr == CLB_ADDR_IF) begin
            rd_val = r_reg.iflag;
        end else if (reg_addr >= CLB_ADDR_BT0 && reg_addr <= CLB_ADDR_BT2) begin
            rd_val = r_reg.bt[2'(reg_addr - CLB_ADDR_BT0)];
        end else if (reg_addr >= CLB_ADDR_FILT0 && reg_addr < CLB_ADDR_FILT0 + 8'(2 * CLB_NFILT)) begin
            rd_val = fidx[0] ? r_reg.filt[fidx[3:1]][7:0] : {5'h00, r_reg.filt[fidx[3:1]][10:8]};
        end else if (reg_addr >= CLB_ADDR_MASK0 && reg_addr < CLB_ADDR_MASK0 + 8'h04) begin
            rd_val = reg_addr[0] ? r_reg.mask[reg_addr[1]][7:0] : {5'h00, r_reg.mask[reg_addr[1]][10:8]};
        end else if (tx_page) begin
            if (fld == CLB_BUF_CTRL) begin
                rd_val = 8'(r_reg.tx_req[bufn]) << CLB_TX_REQ_BIT;
            end else if (fld == CLB_BUF_IDHI) begin
                rd_val = {5'h00, r_reg.txid[bufn][10:8]};
            end else if (fld == CLB_BUF_IDLO) begin
                rd_val = r_reg.txid[bufn][7:0];
            end else if (fld == CLB_BUF_LEN) begin
                rd_val = {4'h0, r_reg.txlen[bufn]};
            end else if (fld >= CLB_BUF_DATA0 && fld <= CLB_BUF_DATA7) begin
                rd_val = r_reg.txdat[bufn][didx];
            end
        end else if (rx_page) begin
            // looped frames are shown here unchanged
            if (fld == CLB_BUF_IDHI) begin
                rd_val = {5'h00, r_reg.rxid[bufn][10:8]};
            end else if (fld == CLB_BUF_IDLO) begin
                rd_val = r_reg.rxid[bufn][7:0];
            end else if (fld == CLB_BUF_LEN) begin
                rd_val = {4'h0, r_reg.rxlen[bufn]};
            end else if (fld >= CLB_BUF_DATA0 && fld <= CLB_BUF_DATA7) begin
                rd_val = r_reg.rxdat[bufn][didx];
            end
        end
        r_next.rdata = reg_rd ? rd_val : 8'h00;

        // host writes first, so hardware events below win over a same-cycle clear
        if (reg_wr) begin
            if (reg_addr == CLB_ADDR_MODE) begin
                r_next.mode = reg_wdata;
            end else if (reg_addr == CLB_ADDR_IE) begin
                r_next.ie = reg_wdata;
            end else if (reg_addr == CLB_ADDR_IF) begin
                r_next.iflag = reg_wdata;
            end else if (reg_addr >= CLB_ADDR_BT0 && reg_addr <= CLB_ADDR_BT2 && cfg_mode) begin
                r_next.bt[2'(reg_addr - CLB_ADDR_BT0)] = reg_wdata;
            end else if (reg_addr >= CLB_ADDR_FILT0 && reg_addr < CLB_ADDR_FILT0 + 8'(2 * CLB_NFILT)
                         && cfg_mode) begin
                if (fidx[0]) begin
                    r_next.filt[fidx[3:1]][7:0] = reg_wdata;
                end else begin
                    r_next.filt[fidx[3:1]][10:8] = reg_wdata[2:0];
                end
            end else if (reg_addr >= CLB_ADDR_MASK0 && reg_addr < CLB_ADDR_MASK0 + 8'h04 && cfg_mode) begin
                if (reg_addr[0]) begin
                    r_next.mask[reg_addr[1]][7:0] = reg_wdata;
                end else begin
                    r_next.mask[reg_addr[1]][10:8] = reg_wdata[2:0];
                end
            end else if (tx_page) begin
                if (fld == CLB_BUF_CTRL) begin
                    r_next.tx_req[bufn] = reg_wdata[CLB_TX_REQ_BIT];
                    ctrl_wr_sel = (bufn == r_reg.sel);
                end else if (fld == CLB_BUF_IDHI) begin
                    r_next.txid[bufn][10:8] = reg_wdata[2:0];
                end else if (fld == CLB_BUF_IDLO) begin
                    r_next.txid[bufn][7:0] = reg_wdata;
                end else if (fld == CLB_BUF_LEN) begin
                    r_next.txlen[bufn] = reg_wdata[3:0];
                end else if (fld >= CLB_BUF_DATA0 && fld <= CLB_BUF_DATA7) begin
                    r_next.txdat[bufn][didx] = reg_wdata;
                end
            end
        end

        // bit timing is never consulted: loopback delivers frames internally
        case (r_reg.st)
            CLB_IDLE: begin
                if (mode == CLB_MODE_LOOPBACK && |r_reg.tx_req) begin
                    r_next.st = CLB_SEND;
                    r_next.sel = !r_reg.tx_req[0];
                end
            end
            CLB_SEND: begin
                // a full buffer is never overwritten; a frame refused by a full rx0 goes to rx1 only if it also hits an rx1 filter
                if (hit_rx0 && !r_reg.iflag[CLB_RX0_FULL_BIT]) begin
                    r_next.rxid[0] = r_reg.txid[r_reg.sel];
                    r_next.rxlen[0] = r_reg.txlen[r_reg.sel];
                    r_next.rxdat[0] = r_reg.txdat[r_reg.sel];
                    r_next.iflag[CLB_RX0_FULL_BIT] = 1'b1;
                end else if (hit_rx1 && !r_reg.iflag[CLB_RX1_FULL_BIT]) begin
                    r_next.rxid[1] = r_reg.txid[r_reg.sel];
                    r_next.rxlen[1] = r_reg.txlen[r_reg.sel];
                    r_next.rxdat[1] = r_reg.txdat[r_reg.sel];
                    r_next.iflag[CLB_RX1_FULL_BIT] = 1'b1;
                end
                r_next.iflag[r_reg.sel ? CLB_TX1_DONE_BIT : CLB_TX0_DONE_BIT] = 1'b1;
                if (!ctrl_wr_sel) begin
                    r_next.tx_req[r_reg.sel] = 1'b0;
                end
                r_next.st = CLB_IDLE;
            end
            default: begin
                r_next.st = CLB_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
            r_reg.mode <= CLB_MODE_RESET;
            r_reg.ie <= CLB_IE_RESET;
            r_reg.iflag <= CLB_IF_RESET;
            r_reg.st <= CLB_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign irq_n = ~|(r_reg.ie & r_reg.iflag);

    logic wr_if;
    logic wr_ie;
    logic wr_sel_ctrl;
    assign wr_if = reg_wr && reg_addr == CLB_ADDR_IF;
    assign wr_ie = reg_wr && reg_addr == CLB_ADDR_IE;
    assign wr_sel_ctrl = reg_wr && tx_page && fld == CLB_BUF_CTRL && bufn == r_reg.sel;

    sequence s_rx0_ready;
        r_reg.st == CLB_SEND && hit_rx0 && !r_reg.iflag[CLB_RX0_FULL_BIT] && !wr_if;
    endsequence
    sequence s_rx0_loaded;
        r_reg.iflag[CLB_RX0_FULL_BIT] && r_reg.rxid[0] == $past(r_reg.txid[r_reg.sel])
            && r_reg.rxdat[0] == $past(r_reg.txdat[r_reg.sel]);
    endsequence

    a_rx0_accept: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_rx0_ready |=> s_rx0_loaded)
        else $error("looped frame not stored in receive buffer 0");
    a_rx0_full_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.st == CLB_SEND && r_reg.iflag[CLB_RX0_FULL_BIT] |=> $stable(r_reg.rxid[0]))
        else $error("full receive buffer 0 was overwritten");
    a_tx_req_autoclr: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.st == CLB_SEND && !wr_sel_ctrl |=> !r_reg.tx_req[$past(r_reg.sel)] && r_reg.st == CLB_IDLE)
        else $error("transmit request not cleared after loopback");
    a_tx1_select: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.st == CLB_IDLE && mode == CLB_MODE_LOOPBACK && r_reg.tx_req == 2'b10
            |=> r_reg.st == CLB_SEND && r_reg.sel)
        else $error("transmit buffer 1 not sent");
    a_filter_lock: assert property (@(posedge core_clk) disable iff (!arst_n)
        !cfg_mode && !(reg_wr && reg_addr == CLB_ADDR_MODE) |=> $stable(r_reg.filt) && $stable(r_reg.mask))
        else $error("filter changed outside configuration mode");
    a_no_send_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.st == CLB_IDLE && mode != CLB_MODE_LOOPBACK |=> r_reg.st == CLB_IDLE)
        else $error("frame sent outside loopback mode");
    a_ie_rx0_only: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_ie && reg_wdata == 8'h01 |=> irq_n == !r_reg.iflag[CLB_RX0_FULL_BIT])
        else $error("rx0 full did not assert interrupt");
    a_irq_release: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_if && reg_wdata == 8'h00 && r_reg.st == CLB_IDLE && !wr_ie |=> irq_n [*1] ##1 1'b1)
        else $error("interrupt stayed active after flags cleared");
    a_flag_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_if && r_reg.st == CLB_IDLE |=> r_reg.iflag == $past(reg_wdata))
        else $error("host flag write lost");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.ie[CLB_RX1_FULL_BIT] && r_reg.iflag[CLB_RX1_FULL_BIT] |-> !irq_n)
        else $error("enabled flag did not assert interrupt");
    a_rx_readback: assert property (@(posedge core_clk) disable iff (!arst_n)
        reg_rd && reg_addr == {CLB_RXBUF_PAGE, 1'b0, CLB_BUF_IDLO} |=> reg_rdata == $past(r_reg.rxid[0][7:0]))
        else $error("receive buffer read returned wrong identifier");

    sequence s_loop_start;
        r_reg.st == CLB_IDLE && mode == CLB_MODE_LOOPBACK && |r_reg.tx_req;
    endsequence

    // the send logic never reads the timing registers, so in loopback mode a request alone starts a send
    a_send_untimed: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_loop_start |=> r_reg.st == CLB_SEND)
        else $error("loopback send waited on bit timing");
    a_tx0_first: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_loop_start ##0 r_reg.tx_req[0] |=> !r_reg.sel)
        else $error("transmit buffer 0 lost its priority");
    a_rx0_length: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_rx0_ready |=> r_reg.rxlen[0] == $past(r_reg.txlen[r_reg.sel]))
        else $error("looped length code not stored");
    a_rx0_irq: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_rx0_ready ##0 (r_reg.ie == 8'h01 && !wr_ie) |=> !irq_n)
        else $error("frame into receive buffer 0 raised no interrupt");
    a_rx0_data_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.st == CLB_SEND && r_reg.iflag[CLB_RX0_FULL_BIT]
            |=> $stable(r_reg.rxdat[0]) && $stable(r_reg.rxlen[0]))
        else $error("full receive buffer 0 data was overwritten");
    a_mode_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        reg_wr && reg_addr == CLB_ADDR_MODE |=> r_reg.mode == $past(reg_wdata))
        else $error("mode register write lost");
    a_ie_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_ie |=> r_reg.ie == $past(reg_wdata))
        else $error("enable register write lost");
    a_tx0_done: assert property (@(posedge core_clk) disable iff (!arst_n)
        r_reg.st == CLB_SEND && !r_reg.sel |=> r_reg.iflag[CLB_TX0_DONE_BIT])
        else $error("transmit buffer 0 done flag not set");
    a_rdata_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data shown without a read");
    a_rx0_free: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_if && !reg_wdata[CLB_RX0_FULL_BIT] && r_reg.st == CLB_IDLE |=> !r_reg.iflag[CLB_RX0_FULL_BIT])
        else $error("receive buffer 0 flag not cleared");
    a_mask_cfg_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        cfg_mode && reg_wr && reg_addr == CLB_ADDR_MASK0 + 8'h01 |=> r_reg.mask[0][7:0] == $past(reg_wdata))
        else $error("mask write in configuration lost");
endmodule
`default_nettype wire

// ### sim/clb_host.sv
// host model that drives the register port of the loopback controller
`timescale 1ns/1ns
`default_nettype none
module clb_host
    import clb_pkg::*;
(
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // released lines flip so that a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
    task automatic wr_id(input logic [7:0] base, input logic [10:0] id);
        wr(base, {5'h00, id[10:8]});
        wr(base + 8'h01, id[7:0]);
    endtask
    // filters and masks only while the mode field says configuration
    task automatic setup_filters();
        wr(CLB_ADDR_MODE, {CLB_MODE_CONFIG, 5'h00});
        wr_id(CLB_ADDR_FILT0, 11'h0aa);
        wr_id(CLB_ADDR_FILT0 + 8'h02, 11'h055);
        wr_id(CLB_ADDR_FILT0 + 8'h04, 11'h123);
        wr_id(CLB_ADDR_MASK0, 11'h7ff);
        wr_id(CLB_ADDR_MASK0 + 8'h02, 11'h7ff);
    endtask
    task automatic send(input int n);
        wr(8'(32 + 16 * n), 8'h08);
    endtask
    task automatic clear_flags();
        wr(CLB_ADDR_IF, 8'h00);
    endtask
endmodule
`default_nettype wire

// ### sim/clb_core_tb.sv
// self-checking testbench for the loopback transmit and receive path
`timescale 1ns/1ns
`default_nettype none
module clb_core_tb
    import clb_pkg::*;
;
    logic core_clk;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic irq_n;
    logic [7:0] v;
    int num_errors;
    int n_compared;

    always #10 core_clk = ~core_clk;

    clb_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    clb_core DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_n(irq_n));

    task automatic final_report();
        $display("errors %0d, compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk(v, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic irq(input logic exp);
        chk({7'h00, irq_n}, {7'h00, exp});
    endtask
    // n picks the transmit buffer that was expected to land in rx0
    task automatic check_rx(input logic [10:0] id, input int n);
        rchk(8'h41, {5'h00, id[10:8]});
        rchk(8'h42, id[7:0]);
        rchk(8'h43, 8'h08);
        for (int i = 0; i < 8; i++) begin
            rchk(8'(68 + i), 8'(16 * (n + 1) + i));
        end
    endtask

    initial begin
        #500000;
        num_errors++;
        final_report();
    end

    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        irq(1'b1);
        rchk(CLB_ADDR_MODE, {CLB_MODE_CONFIG, 5'h00});
        rchk(CLB_ADDR_IF, 8'h00);
        host.wr(CLB_ADDR_IF, 8'h01);
        cyc(1);
        irq(1'b1);
        rchk(CLB_ADDR_IF, 8'h01);
        host.wr(CLB_ADDR_IE, 8'h01);
        cyc(1);
        irq(1'b0);
        host.wr(CLB_ADDR_IF, 8'h04);
        cyc(1);
        irq(1'b1);
        host.wr(CLB_ADDR_IE, 8'h02);
        host.wr(CLB_ADDR_IF, 8'h02);
        cyc(1);
        irq(1'b0);
        host.wr(CLB_ADDR_IE, 8'h01);
        cyc(1);
        irq(1'b1);
        host.clear_flags();
        host.setup_filters();
        // no bit timing is ever written: loopback must work without it
        for (int n = 0; n < 2; n++) begin
            host.wr_id(8'(33 + 16 * n), n == 0 ? 11'h0aa : 11'h055);
            host.wr(8'(35 + 16 * n), 8'h08);
            for (int i = 0; i < 8; i++) begin
                host.wr(8'(36 + 16 * n + i), 8'(16 * (n + 1) + i));
            end
        end
        // normal mode must leave a pending request untouched
        host.wr(CLB_ADDR_MODE, {CLB_MODE_NORMAL, 5'h00});
        host.send(0);
        cyc(3);
        rchk(CLB_ADDR_IF, 8'h00);
        rchk(8'h20, 8'h08);
        host.wr(8'h20, 8'h00);
        host.wr(CLB_ADDR_MODE, {CLB_MODE_LOOPBACK, 5'h00});
        rchk(CLB_ADDR_MODE, {CLB_MODE_LOOPBACK, 5'h00});
        // outside configuration this filter write must be dropped
        host.wr(CLB_ADDR_FILT0 + 8'h01, 8'h00);
        host.send(0);
        cyc(1);
        irq(1'b1);
        cyc(1);
        irq(1'b0);
        rchk(CLB_ADDR_IF, 8'h05);
        rchk(8'h20, 8'h00);
        check_rx(11'h0aa, 0);
        // rx0 is still full, so the second frame must not overwrite it
        host.send(1);
        cyc(3);
        rchk(CLB_ADDR_IF, 8'h0d);
        rchk(8'h30, 8'h00);
        check_rx(11'h0aa, 0);
        host.clear_flags();
        cyc(1);
        irq(1'b1);
        host.send(1);
        cyc(3);
        irq(1'b0);
        check_rx(11'h055, 1);
        rchk(8'h7f, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
